// File: dsr_pkg.sv
// Shared constants, types and the register map of the decimator sync and readout block.
package dsr_pkg;

  // Register map, byte addresses on APB.
  localparam int          APB_AW       = 12;
  localparam logic [11:0] OFS_CTRL     = 12'h000;
  localparam logic [11:0] OFS_STATUS   = 12'h004;
  localparam logic [11:0] OFS_RESULT   = 12'h008;
  localparam logic [11:0] OFS_COMP     = 12'h00C;
  localparam logic [11:0] OFS_REALIGN  = 12'h010;

  // Control register fields and reset value.
  localparam int          CTRL_DF_LSB  = 0;
  localparam logic [1:0]  CTRL_DF_RST  = 2'h0;

  // Status register fields.
  localparam int          STAT_BUSY    = 0;
  localparam int          STAT_FLAG    = 1;
  localparam int          STAT_LOCK    = 2;
  localparam int          STAT_PH_LSB  = 16;

  // Word widths.
  localparam int          DIFF_W       = 14;
  localparam int          CM_W         = 8;
  localparam int          COMP_W       = 22;
  localparam int          RESULT_W     = 32;
  localparam int          TAG_W        = 8;
  localparam int          FWORD_W      = 40;
  localparam int          PHASE_W      = 14;
  localparam int          REALIGN_W    = 16;

  // Decimation factor minus one, one per setting.
  localparam logic [13:0] DFM1_256     = 14'h00FF;
  localparam logic [13:0] DFM1_1024    = 14'h03FF;
  localparam logic [13:0] DFM1_4096    = 14'h0FFF;
  localparam logic [13:0] DFM1_16384   = 14'h3FFF;

  // Configuration tags appended after the filtered result.
  localparam logic [7:0]  TAG_256      = 8'h85;
  localparam logic [7:0]  TAG_1024     = 8'hA5;
  localparam logic [7:0]  TAG_4096     = 8'hC5;
  localparam logic [7:0]  TAG_16384    = 8'hE5;

  // Conversion timing.
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          CONV_TIME_NS  = 500;
  localparam int          CONV_CYCLES   = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    DF_256   = 2'b00,
    DF_1024  = 2'b01,
    DF_4096  = 2'b10,
    DF_16384 = 2'b11
  } dsr_df_e;

  typedef enum logic {
    CONV_IDLE = 1'b0,
    CONV_BUSY = 1'b1
  } dsr_conv_e;

  typedef struct packed {
    logic [DIFF_W-1:0] diff;
    logic [CM_W-1:0]   cm;
  } dsr_composite_s;

endpackage

// File: dsr_shift_out.sv
// Serial output shifter gated by an active-low read select.
`timescale 1ns/1ps
module dsr_shift_out
  import dsr_pkg::*;
#(
  parameter int WIDTH = 32
) (
  // Clock and reset.
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Control from the synchronised pins.
  input  wire logic             sel_n,
  input  wire logic             shift,
  // Word to send.
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] word,
  // Serial pin.
  output logic                  shared_serial_line,
  output logic                  sdo_oe
);

  initial begin
    if (WIDTH < 2) begin
      $error("dsr_shift_out needs WIDTH of at least 2");
    end
  end

  logic             sel_q;
  logic [WIDTH-1:0] shreg;
  logic             next_sel_q;
  logic [WIDTH-1:0] next_shreg;
  logic             next_oe;

  always_comb begin
    next_sel_q = sel_n;
    next_oe    = ~sel_n;
    next_shreg = shreg;
    // Select falling reloads so the top bit is on the pin at once.
    if ((sel_q && !sel_n) || load) begin
      next_shreg = word;
    end else if (shift && !sel_n) begin
      next_shreg = {shreg[WIDTH-2:0], 1'b0};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_q  <= 1'b1;
      shreg  <= '0;
      sdo_oe <= 1'b0;
    end else begin
      sel_q  <= next_sel_q;
      shreg  <= next_shreg;
      sdo_oe <= next_oe;
    end
  end

  assign shared_serial_line = shreg[WIDTH-1];

endmodule

// File: dsr_top.sv
// Decimator synchronisation, result formatting and dual serial readout.
//
// Summary of operation
// - Filter refreshes every conversion; result register loads once per decimation factor.
// - After an alignment pulse, updates fall on every multiple of the factor.
// - Update flag output marks the conversion that updates the result register.
// - An alignment pulse matching the current alignment changes nothing.
// - After an extra conversion the next alignment pulse restores alignment.
// - Changing or re-establishing alignment clears the decimation filter state.
// - Direct register holds the 22-bit composite of the latest sample.
// - First 14 composite bits are the differential value, MSB first.
// - Last 8 composite bits are common-mode two's complement, MSB first.
// - Filtered output appends an 8-bit tag after the 32-bit result.
// - Tag encodes the factor: 85, A5, C5, E5 hex for 256 to 16384.
// - Filtered select low enables output; MSB appears after update flag falls.
// - Lowering filtered select puts the result MSB on the filtered output.
// - Direct select low enables output; composite MSB appears after busy falls.
// - Lowering direct select puts the composite MSB on the direct output.
// - On a shared line each select puts its own word's MSB there.
// - Update flag rises at start of each factor-th conversion, falls at its end.
// - Filtered result stays readable across many conversions for slow clocks.
//
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module dsr_top
  import dsr_pkg::*;
#(
  parameter int CONV_CYC = CONV_CYCLES
) (
  // Clock and reset.
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // APB slave.
  input  wire logic [APB_AW-1:0]     paddr,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic                       pready,
  output logic [31:0]                prdata,
  output logic                       pslverr,
  // Host pins, asynchronous to pclk.
  input  wire logic                  conv_clock_pin,
  input  wire logic                  align_pulse,
  input  wire logic                  filtered_serial_clock,
  input  wire logic                  direct_serial_clock,
  input  wire logic                  filtered_read_select_n,
  input  wire logic                  direct_read_select_n,
  // Output pins.
  output logic                       busy,
  output logic                       filtered_update_flag,
  output logic                       filtered_serial_out,
  output logic                       filtered_serial_oe,
  output logic                       direct_serial_out,
  output logic                       direct_serial_oe,
  // Converter core and filter datapath, on pclk.
  input  wire dsr_composite_s        core_sample,
  input  wire logic [RESULT_W-1:0]   filter_value,
  output logic                       filter_refresh,
  output logic                       filter_clear
);

  initial begin
    if (CONV_CYC < 2) begin
      $error("dsr_top needs CONV_CYC of at least 2");
    end
  end

  localparam int CW = $clog2(CONV_CYC + 1);
  localparam logic [CW-1:0] CONV_LAST = CW'(CONV_CYC - 1);
  localparam int NPIN = 6;

  // Two-flop synchronisers for every pin input.
  logic [NPIN-1:0] pin_meta;
  logic [NPIN-1:0] pin_sync;
  logic [NPIN-1:0] pin_prev;
  logic [NPIN-1:0] next_pin_prev;

  always_comb begin
    next_pin_prev = pin_sync;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta <= 6'h30;
      pin_sync <= 6'h30;
      pin_prev <= 6'h30;
    end else begin
      pin_meta <= {filtered_read_select_n, direct_read_select_n, filtered_serial_clock,
                   direct_serial_clock, align_pulse, conv_clock_pin};
      pin_sync <= pin_meta;
      pin_prev <= next_pin_prev;
    end
  end

  logic conv_rise;
  logic align_rise;
  logic fsck_fall;
  logic dsck_fall;
  assign conv_rise  = pin_sync[0] & ~pin_prev[0];
  assign align_rise = pin_sync[1] & ~pin_prev[1];
  assign dsck_fall  = ~pin_sync[2] & pin_prev[2];
  assign fsck_fall  = ~pin_sync[3] & pin_prev[3];

  // Conversion, decimation phase and alignment state.
  dsr_conv_e               conv_state;
  logic [CW-1:0]           conv_cnt;
  logic [PHASE_W-1:0]      phase;
  logic                    locked;
  dsr_composite_s          sample_hold;
  dsr_composite_s          composite;
  logic [RESULT_W-1:0]     result;
  logic [TAG_W-1:0]        tag;
  logic [REALIGN_W-1:0]    realign_cnt;
  logic                    fload;
  logic                    dload;
  logic [1:0]              df_sel;

  dsr_conv_e               next_conv_state;
  logic [CW-1:0]           next_conv_cnt;
  logic [PHASE_W-1:0]      next_phase;
  logic                    next_locked;
  dsr_composite_s          next_sample_hold;
  dsr_composite_s          next_composite;
  logic [RESULT_W-1:0]     next_result;
  logic [TAG_W-1:0]        next_tag;
  logic [REALIGN_W-1:0]    next_realign_cnt;
  logic                    next_fload;
  logic                    next_dload;
  logic                    next_busy;
  logic                    next_flag;
  logic                    next_refresh;
  logic                    next_clear;
  logic [PHASE_W-1:0]      df_m1;
  logic [TAG_W-1:0]        df_tag;

  always_comb begin
    unique case (dsr_df_e'(df_sel))
      DF_256:   df_m1 = DFM1_256;
      DF_1024:  df_m1 = DFM1_1024;
      DF_4096:  df_m1 = DFM1_4096;
      DF_16384: df_m1 = DFM1_16384;
    endcase
  end

  always_comb begin
    unique case (dsr_df_e'(df_sel))
      DF_256:   df_tag = TAG_256;
      DF_1024:  df_tag = TAG_1024;
      DF_4096:  df_tag = TAG_4096;
      DF_16384: df_tag = TAG_16384;
    endcase
  end

  always_comb begin
    next_conv_state  = conv_state;
    next_conv_cnt    = conv_cnt;
    next_phase       = phase;
    next_locked      = locked;
    next_sample_hold = sample_hold;
    next_composite   = composite;
    next_result      = result;
    next_tag         = tag;
    next_realign_cnt = realign_cnt;
    next_fload       = 1'b0;
    next_dload       = 1'b0;
    next_busy        = busy;
    next_flag        = filtered_update_flag;
    next_refresh     = 1'b0;
    next_clear       = 1'b0;
    unique case (conv_state)
      CONV_IDLE: begin
        // A conversion edge while busy is ignored, so only idle edges count.
        if (conv_rise) begin
          next_conv_state  = CONV_BUSY;
          next_conv_cnt    = '0;
          next_busy        = 1'b1;
          next_sample_hold = core_sample;
          // A factor change mid-count is caught by the compare, not missed.
          if (phase >= df_m1) begin
            next_flag  = 1'b1;
            next_phase = '0;
          end else begin
            next_phase = phase + 14'h0001;
          end
        end
      end
      CONV_BUSY: begin
        next_conv_cnt = conv_cnt + CW'(1);
        if (conv_cnt == CONV_LAST) begin
          next_conv_state = CONV_IDLE;
          next_busy       = 1'b0;
          next_flag       = 1'b0;
          next_composite  = sample_hold;
          next_dload      = 1'b1;
          next_refresh    = 1'b1;
          if (filtered_update_flag) begin
            next_result = filter_value;
            next_tag    = df_tag;
            next_fload  = 1'b1;
          end
        end
      end
    endcase
    // Alignment is applied after the conversion edge so a coincident pair counts once.
    if (align_rise) begin
      next_locked = 1'b1;
      if (next_phase != '0) begin
        next_phase       = '0;
        next_clear       = 1'b1;
        next_realign_cnt = realign_cnt + 16'h0001;
      end
      // Phase already zero means the pulse matches; nothing is disturbed.
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_state           <= CONV_IDLE;
      conv_cnt             <= '0;
      phase                <= '0;
      locked               <= 1'b0;
      sample_hold          <= '0;
      composite            <= '0;
      result               <= '0;
      tag                  <= TAG_256;
      realign_cnt          <= '0;
      fload                <= 1'b0;
      dload                <= 1'b0;
      busy                 <= 1'b0;
      filtered_update_flag <= 1'b0;
      filter_refresh       <= 1'b0;
      filter_clear         <= 1'b0;
    end else begin
      conv_state           <= next_conv_state;
      conv_cnt             <= next_conv_cnt;
      phase                <= next_phase;
      locked               <= next_locked;
      sample_hold          <= next_sample_hold;
      composite            <= next_composite;
      result               <= next_result;
      tag                  <= next_tag;
      realign_cnt          <= next_realign_cnt;
      fload                <= next_fload;
      dload                <= next_dload;
      busy                 <= next_busy;
      filtered_update_flag <= next_flag;
      filter_refresh       <= next_refresh;
      filter_clear         <= next_clear;
    end
  end

  // Serial outputs. The filtered word reloads only on a new result or a falling select, so a
  // slow reader may spread its bits over many conversions.
  dsr_shift_out #(
    .WIDTH   (FWORD_W)
  ) u_filtered (
    .pclk    (pclk),
    .presetn (presetn),
    .sel_n   (pin_sync[5]),
    .shift   (fsck_fall),
    .load    (fload),
    .word    ({result, tag}),
    .shared_serial_line     (filtered_serial_out),
    .sdo_oe  (filtered_serial_oe)
  );

  dsr_shift_out #(
    .WIDTH   (COMP_W)
  ) u_direct (
    .pclk    (pclk),
    .presetn (presetn),
    .sel_n   (pin_sync[4]),
    .shift   (dsck_fall),
    .load    (dload),
    .word    (composite),
    .shared_serial_line     (direct_serial_out),
    .sdo_oe  (direct_serial_oe)
  );

  // APB slave with one wait state; every answer is registered.
  logic        access;
  logic        hit;
  logic [31:0] rd_mux;
  logic        next_pready;
  logic [31:0] next_prdata;
  logic        next_pslverr;
  logic [1:0]  next_df_sel;

  assign access = psel & penable;

  always_comb begin
    hit    = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      OFS_CTRL:    rd_mux[CTRL_DF_LSB +: 2] = df_sel;
      OFS_STATUS: begin
        rd_mux[STAT_BUSY] = busy;
        rd_mux[STAT_FLAG] = filtered_update_flag;
        rd_mux[STAT_LOCK] = locked;
        rd_mux[STAT_PH_LSB +: PHASE_W] = phase;
      end
      OFS_RESULT:  rd_mux = result;
      OFS_COMP:    rd_mux[COMP_W-1:0] = composite;
      OFS_REALIGN: rd_mux[REALIGN_W-1:0] = realign_cnt;
      default:     hit = 1'b0;
    endcase
  end

  always_comb begin
    next_pready  = access & ~pready;
    next_prdata  = prdata;
    next_pslverr = 1'b0;
    next_df_sel  = df_sel;
    if (access && !pready) begin
      next_prdata  = pwrite ? prdata : (hit ? rd_mux : 32'h0000_0000);
      next_pslverr = ~hit;
    end
    // Writes commit at the edge that samples pready high, as the master expects.
    if (access && pready && pwrite && (paddr == OFS_CTRL) && pstrb[0]) begin
      next_df_sel = pwdata[CTRL_DF_LSB +: 2];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
      df_sel  <= CTRL_DF_RST;
    end else begin
      pready  <= next_pready;
      prdata  <= next_prdata;
      pslverr <= next_pslverr;
      df_sel  <= next_df_sel;
    end
  end

endmodule

// File: dsr_props.sv
// Concurrent checks on the pins of the decimator sync and readout block.
`timescale 1ns/1ps
module dsr_props
  import dsr_pkg::*;
#(
  parameter int CONV_CYC = CONV_CYCLES
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Bus handshake.
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Host pins.
  input wire logic align_pulse,
  input wire logic filtered_read_select_n,
  input wire logic direct_read_select_n,
  // Device outputs.
  input wire logic busy,
  input wire logic filtered_update_flag,
  input wire logic filtered_serial_oe,
  input wire logic direct_serial_oe,
  input wire logic filter_refresh,
  input wire logic filter_clear
);
  int busy_len;
  int align_age;
  int next_busy_len;
  int next_align_age;

  // The age saturates so that a long quiet spell cannot wrap it back into range.
  always_comb begin
    next_busy_len  = busy ? busy_len + 1 : 0;
    next_align_age = align_pulse ? 0 : (align_age < 99 ? align_age + 1 : 99);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_len  <= 0;
      align_age <= 99;
    end else begin
      busy_len  <= next_busy_len;
      align_age <= next_align_age;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence busy_end;
    $fell(busy);
  endsequence

  busy_width_a: assert property (busy_end |-> busy_len == CONV_CYC)
    else $error("busy width wrong");
  flag_in_busy_a: assert property (filtered_update_flag |-> busy)
    else $error("update flag outside conversion");
  flag_start_a: assert property ($rose(filtered_update_flag) |-> $rose(busy))
    else $error("update flag late");
  refresh_each_a: assert property (1'b1 |-> filter_refresh == $fell(busy))
    else $error("filter refresh off conversion end");
  clear_cause_a: assert property (filter_clear |-> align_age <= 8)
    else $error("filter clear without alignment");
  fsel_off_a: assert property (filtered_read_select_n [*5] |-> !filtered_serial_oe)
    else $error("filtered output not released");
  dsel_off_a: assert property (direct_read_select_n [*5] |-> !direct_serial_oe)
    else $error("direct output not released");
  fsel_on_a: assert property (!filtered_read_select_n [*5] |-> filtered_serial_oe)
    else $error("filtered output not driven");
  dsel_on_a: assert property (!direct_read_select_n [*5] |-> direct_serial_oe)
    else $error("direct output not driven");
  ready_answer_a: assert property (psel && penable && !pready |-> ##[1:2] pready)
    else $error("bus answer late");
  ready_once_a: assert property (pready |=> !pready)
    else $error("ready held too long");
endmodule

bind dsr_top dsr_props #(.CONV_CYC(CONV_CYC)) dsr_props_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .align_pulse(align_pulse),
  .filtered_read_select_n(filtered_read_select_n),
  .direct_read_select_n(direct_read_select_n), .busy(busy),
  .filtered_update_flag(filtered_update_flag), .filtered_serial_oe(filtered_serial_oe),
  .direct_serial_oe(direct_serial_oe), .filter_refresh(filter_refresh),
  .filter_clear(filter_clear)
);

// File: dsr_host_model.sv
// Host controller model: conversion clock, alignment pulse and serial reads.
`timescale 1ns/1ps
module dsr_host_model (
  // Clock.
  input  wire logic   pclk,
  // Device serial outputs, both wired to one shared line.
  input  wire logic   f_out,
  input  wire logic   f_oe,
  input  wire logic   d_out,
  input  wire logic   d_oe,
  // Pins toward the device.
  output logic        conv_pin,
  output logic        align,
  output logic        sck,
  output logic        fsel_n,
  output logic        dsel_n,
  // Finished reads.
  output logic        rd_done,
  output logic [39:0] rd_word
);
  logic line;
  logic last;

  // A released line shows no stale bit: it flips every cycle instead.
  assign line = f_oe ? f_out : (d_oe ? d_out : ~last);

  always @(posedge pclk) begin
    last <= line;
  end

  initial begin
    {conv_pin, align, sck, rd_done, last} = 5'h00;
    {fsel_n, dsel_n} = 2'h3;
    rd_word = 40'h0;
  end

  // Reads and pulses happen only while conversions are paused.
  task automatic conv(input int n);
    repeat (n) begin
      conv_pin <= 1'b1;
      repeat (5) @(posedge pclk);
      conv_pin <= 1'b0;
      repeat (10) @(posedge pclk);
    end
  endtask

  task automatic sync_pulse();
    align <= 1'b1;
    repeat (4) @(posedge pclk);
    align <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask

  // Selects idle high and only one is lowered at a time.
  task automatic read(input logic filt, input int n);
    logic [39:0] w;
    w = 40'h0;
    fsel_n <= !filt;
    dsel_n <= filt;
    repeat (8) @(posedge pclk);
    for (int i = 0; i < n; i++) begin
      sck <= 1'b1;
      repeat (8) @(posedge pclk);
      w = {w[38:0], line};
      sck <= 1'b0;
      repeat (8) @(posedge pclk);
    end
    {fsel_n, dsel_n} <= 2'h3;
    rd_word <= w;
    rd_done <= 1'b1;
    @(posedge pclk);
    rd_done <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask
endmodule

// File: tb.sv
// Self-checking bench for the decimator sync and readout block.
`timescale 1ns/1ps
module tb
  import dsr_pkg::*;
;
  logic           pclk;
  logic           presetn;
  logic [11:0]    paddr;
  logic           psel;
  logic           penable;
  logic           pwrite;
  logic [31:0]    pwdata;
  logic [3:0]     pstrb;
  logic           pready;
  logic [31:0]    prdata;
  logic           pslverr;
  logic           conv_pin;
  logic           align;
  logic           sck;
  logic           fsel_n;
  logic           dsel_n;
  logic           busy;
  logic           busy_d;
  logic           flag;
  logic           f_out;
  logic           f_oe;
  logic           d_out;
  logic           d_oe;
  dsr_composite_s core_sample;
  logic [31:0]    filter_value;
  logic           rd_done;
  logic [39:0]    rd_word;
  logic           filter_refresh;
  logic           filter_clear;
  logic [31:0]    fv;
  logic [21:0]    comp;
  logic [39:0]    rd_q[$];
  logic [32:0]    apb_q[$];
  int             cnt_q[$];
  logic [7:0]     tags[4] = '{TAG_256, TAG_1024, TAG_4096, TAG_16384};
  int             fails;
  int             tests_run;
  int             seed;
  int             cnt;
  int             clears;

  dsr_top #(.CONV_CYC(8)) dsr_top_i (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .conv_clock_pin(conv_pin), .align_pulse(align),
    .filtered_serial_clock(sck), .direct_serial_clock(sck),
    .filtered_read_select_n(fsel_n), .direct_read_select_n(dsel_n), .busy(busy),
    .filtered_update_flag(flag), .filtered_serial_out(f_out), .filtered_serial_oe(f_oe),
    .direct_serial_out(d_out), .direct_serial_oe(d_oe), .core_sample(core_sample),
    .filter_value(filter_value), .filter_refresh(filter_refresh), .filter_clear(filter_clear)
  );

  dsr_host_model dsr_host_model_i (
    .pclk(pclk), .f_out(f_out), .f_oe(f_oe), .d_out(d_out), .d_oe(d_oe),
    .conv_pin(conv_pin), .align(align), .sck(sck), .fsel_n(fsel_n), .dsel_n(dsel_n),
    .rd_done(rd_done), .rd_word(rd_word)
  );

  always #5 pclk = ~pclk;

  task automatic check(input string what, input logic [39:0] exp, input logic [39:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // The request stays put until pready is seen high at a rising edge.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [32:0] exp);
    apb_q.push_back(exp);
    apb(1'b0, a, 32'h0);
  endtask

  always @(posedge pclk) begin
    busy_d <= busy;
    if (rd_done) check("serial word", rd_q.pop_front(), rd_word);
    if (psel && penable && pready && !pwrite) begin
      check("bus read", apb_q.pop_front(), {pslverr, prdata});
    end
    if (filter_clear === 1'b1) clears++;
    if (busy === 1'b0 && busy_d === 1'b1) begin
      check("refresh", 40'h1, 40'(filter_refresh));
    end
    if (busy === 1'b1 && busy_d === 1'b0) begin
      cnt = cnt + 1;
      if (flag === 1'b1) begin
        check("update spacing", 40'(cnt_q.pop_front()), 40'(cnt));
        cnt = 0;
      end
    end
    if (align) cnt = 0;
  end

  initial begin
    repeat (98000) @(posedge pclk);
    fails++;
    end_sim();
  end

  initial begin
    {pclk, presetn, psel, penable, pwrite, busy_d} = 6'h00;
    {paddr, pwdata, pstrb} = {12'h000, 32'h0, 4'hF};
    {fails, tests_run, cnt, clears} = {32'h0, 32'h0, 32'h0, 32'h0};
    seed = 32'h9CB9;
    fv = $random(seed);
    comp = 22'($random(seed));
    filter_value = fv;
    core_sample = dsr_composite_s'(comp);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(OFS_CTRL, 33'h0);
    rd(12'h020, 33'h100000000);
    for (int k = 3; k >= 0; k--) begin
      apb(1'b1, OFS_CTRL, 32'(k));
      rd(OFS_CTRL, 33'(k));
    end
    // A write without the low byte strobe must leave the factor alone.
    pstrb <= 4'hE;
    apb(1'b1, OFS_CTRL, 32'h3);
    pstrb <= 4'hF;
    rd(OFS_CTRL, 33'h0);
    dsr_host_model_i.conv(4);
    // The direct word must follow the newest sample, not an older one.
    comp = 22'($random(seed));
    core_sample <= dsr_composite_s'(comp);
    dsr_host_model_i.conv(1);
    rd_q.push_back({18'h0, comp});
    dsr_host_model_i.read(1'b0, 22);
    dsr_host_model_i.sync_pulse();
    cnt_q.push_back(256);
    dsr_host_model_i.conv(256);
    check("clears", 40'h1, 40'(clears));
    rd_q.push_back({fv, TAG_256});
    dsr_host_model_i.read(1'b1, 40);
    rd_q.push_back({8'h00, fv});
    dsr_host_model_i.read(1'b1, 32);
    rd(OFS_RESULT, {1'b0, fv});
    rd(OFS_STATUS, 33'h4);
    rd(OFS_COMP, {11'h0, comp});
    dsr_host_model_i.sync_pulse();
    cnt_q.push_back(256);
    dsr_host_model_i.conv(256);
    check("clears", 40'h1, 40'(clears));
    dsr_host_model_i.conv(1);
    dsr_host_model_i.sync_pulse();
    cnt_q.push_back(256);
    dsr_host_model_i.conv(256);
    check("clears", 40'h2, 40'(clears));
    rd(OFS_REALIGN, 33'h2);
    for (int k = 1; k < 3; k++) begin
      fv = $random(seed);
      filter_value <= fv;
      apb(1'b1, OFS_CTRL, 32'(k));
      cnt_q.push_back(256 << (2 * k));
      dsr_host_model_i.conv(256 << (2 * k));
      rd_q.push_back({fv, tags[k]});
      dsr_host_model_i.read(1'b1, 40);
    end
    end_sim();
  end
endmodule
